// ---- rtl/rxb_receiver.sv ----
`timescale 1ns/1ps
module rxb_receiver (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic serial_in,
  input wire logic serial_input_b_in,
  input wire logic [1:0] mode_sel_in,
  input wire logic self_test_enable_n_in,
  input wire logic reframe_enable_in,
  input wire logic host_ready_in,
  output logic [7:0] parallel_data_out,
  output logic special_char_flag_out,
  output logic receive_violation_flag_out,
  output logic [9:0] raw_ten_bit_out,
  output logic byte_ready_n_out,
  output logic rx_ready_out
);
  // ***************************************************
  // Bit timing and framing
  // ***************************************************
  logic sib_q;
  logic rf_q;
  logic [9:0] shift_q;
  logic [3:0] cnt_q;
  logic sync_wait_q;
  wire test_mode = mode_sel_in == rxb_pkg::MODE_TEST;
  // Test mode steps the shifter on rising edges of the external bit clock
  wire bit_stb = test_mode ? (serial_input_b_in && !sib_q) : 1'b1;
  wire [9:0] shift_d = bit_stb ? {shift_q[8:0], serial_in} : shift_q;
  wire comma_d = (shift_d == rxb_pkg::K285_NEG) || (shift_d == rxb_pkg::K285_POS);
  wire realign = bit_stb && reframe_enable_in && comma_d;
  wire char_end = (bit_stb && cnt_q == rxb_pkg::CNT_LAST) || realign;
  wire [3:0] cnt_d = char_end ? 4'h0 : (bit_stb ? cnt_q + 4'h1 : cnt_q);
  // Ready stays inhibited from the reframe rise until a K28.5 lands
  wire sync_wait_d = (reframe_enable_in && !rf_q) ? 1'b1 :
                     ((char_end && comma_d) ? 1'b0 : sync_wait_q);

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      sib_q <= 1'b0;
      rf_q <= 1'b0;
      shift_q <= 10'h000;
      cnt_q <= 4'h0;
      sync_wait_q <= 1'b0;
    end else begin
      sib_q <= serial_input_b_in;
      rf_q <= reframe_enable_in;
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      sync_wait_q <= sync_wait_d;
    end
  end

  // ***************************************************
  // Character decoder
  // ***************************************************
  function automatic logic [5:0] flip6(input logic [5:0] c);
    flip6 = ($countones(c) != 3 || c == 6'h38) ? ~c : c;
  endfunction
  function automatic logic [3:0] flip4(input logic [3:0] c);
    flip4 = ($countones(c) != 2 || c == 4'hC) ? ~c : c;
  endfunction

  wire [5:0] c6 = shift_d[9:4];
  wire [3:0] c4 = shift_d[3:0];
  logic [31:0] m6;
  logic [7:0] m4;
  logic [4:0] enc6;
  logic [2:0] enc4;
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_six
      assign m6[gi] = c6 == rxb_pkg::T6[gi] || c6 == flip6(rxb_pkg::T6[gi]);
      if (gi < 8) begin : g_four
        assign m4[gi] = c4 == rxb_pkg::T4[gi] || c4 == flip4(rxb_pkg::T4[gi]);
      end
    end
  endgenerate

  always_comb begin
    enc6 = 5'h00;
    enc4 = 3'h0;
    for (int i = 0; i < 32; i++) begin
      if (m6[i]) begin
        enc6 = 5'(i);
      end
    end
    for (int i = 0; i < 8; i++) begin
      if (m4[i]) begin
        enc4 = 3'(i);
      end
    end
  end

  wire k28 = c6 == rxb_pkg::K28_6B || c6 == ~rxb_pkg::K28_6B;
  wire alt7 = c4 == rxb_pkg::ALT7_4B || c4 == ~rxb_pkg::ALT7_4B;
  wire [4:0] dec_x = k28 ? rxb_pkg::K28_X : enc6;
  wire [2:0] dec_y = alt7 ? rxb_pkg::ALT7_Y : enc4;
  wire x_k7 = dec_x == 5'h17 || dec_x == 5'h1B || dec_x == 5'h1D || dec_x == 5'h1E;
  wire dec_bad = !((|m6) || k28) || !((|m4) || alt7);
  wire dec_sc = dec_bad || k28 || (alt7 && x_k7);
  wire dec_rvs = dec_bad;
  wire [7:0] dec_data = dec_bad ? rxb_pkg::BAD_CODE : {dec_y, dec_x};

  // ***************************************************
  // Self-test checker
  // ***************************************************
  rxb_pkg::rxb_bist_t st_q;
  rxb_pkg::rxb_bist_t st_d;
  logic [7:0] lfsr_q;
  wire [7:0] lfsr_nxt = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
  wire init_seen = dec_sc && !dec_rvs && dec_data == rxb_pkg::BIST_INIT;
  wire mismatch = dec_rvs || dec_sc || dec_data != lfsr_q;
  wire loop_end = lfsr_nxt == rxb_pkg::BIST_SEED;

  always_comb begin
    st_d = st_q;
    if (self_test_enable_n_in) begin
      st_d = rxb_pkg::ST_OFF;
    end else begin
      case (st_q)
        rxb_pkg::ST_OFF: st_d = rxb_pkg::ST_WAIT;
        rxb_pkg::ST_WAIT: st_d = (char_end && init_seen) ? rxb_pkg::ST_RUN : rxb_pkg::ST_WAIT;
        rxb_pkg::ST_RUN: st_d = rxb_pkg::ST_RUN;
        default: st_d = rxb_pkg::ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      st_q <= rxb_pkg::ST_OFF;
      lfsr_q <= rxb_pkg::BIST_SEED;
    end else begin
      st_q <= st_d;
      if (st_q != rxb_pkg::ST_RUN) begin
        lfsr_q <= rxb_pkg::BIST_SEED;
      end else if (char_end) begin
        lfsr_q <= lfsr_nxt;
      end
    end
  end

  // ***************************************************
  // Output word selection and fill hold-back
  // ***************************************************
  wire bist_run = st_q == rxb_pkg::ST_RUN;
  wire bist_wait = st_q == rxb_pkg::ST_WAIT;
  // Self-test overrides bypass so the checker always sees decoded bytes
  wire bypass_eff = mode_sel_in == rxb_pkg::MODE_BYP && self_test_enable_n_in;
  wire internal = test_mode || (!self_test_enable_n_in && reframe_enable_in);
  wire [9:0] sel_word = internal ? {sync_wait_d, bist_run, shift_q[7:0]} :
                        bist_run ? {mismatch, 1'b0, lfsr_q} :
                        bypass_eff ? shift_d :
                        {dec_rvs, dec_sc, dec_data};
  wire sel_pulse = bist_run ? loop_end :
                   bist_wait ? init_seen :
                   !sync_wait_d;
  logic pend_valid_q;
  logic pend_k285_q;
  logic pend_pulse_q;
  logic pend_inv_q;
  logic [9:0] pend_word_q;
  logic [9:0] pend_raw_q;
  // One character of look-ahead: a K28.5 followed by another is fill
  wire fill = pend_k285_q && comma_d && !bist_run;
  wire push = char_end && pend_valid_q;
  wire [21:0] push_word = {pend_inv_q, pend_pulse_q && !fill, pend_word_q, pend_raw_q};
  logic buf_valid;
  logic [21:0] buf_word;

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      pend_valid_q <= 1'b0;
      pend_k285_q <= 1'b0;
      pend_pulse_q <= 1'b0;
      pend_inv_q <= 1'b0;
      pend_word_q <= 10'h000;
      pend_raw_q <= 10'h000;
    end else if (char_end) begin
      pend_valid_q <= 1'b1;
      pend_k285_q <= comma_d;
      pend_pulse_q <= sel_pulse;
      pend_inv_q <= bist_run;
      pend_word_q <= sel_word;
      pend_raw_q <= shift_d;
    end
  end

  rxb_pair_buf #(
    .W(rxb_pkg::W_BUF),
    .DEPTH(rxb_pkg::D_BUF)
  ) u_buf (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .in_valid_in(push),
    .in_data_in(push_word),
    .in_ready_out(rx_ready_out),
    .out_valid_out(buf_valid),
    .out_data_out(buf_word),
    .out_ready_in(host_ready_in)
  );

  wire pop = buf_valid && host_ready_in;
  // Self-test idles ready low and pulses it high; normal use is the reverse
  wire rdy_n_d = pop ? (buf_word[20] ? buf_word[21] : !buf_word[21]) : !bist_run;

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      parallel_data_out <= 8'h00;
      special_char_flag_out <= 1'b0;
      receive_violation_flag_out <= 1'b0;
      raw_ten_bit_out <= 10'h000;
      byte_ready_n_out <= 1'b1;
    end else begin
      byte_ready_n_out <= rdy_n_d;
      if (pop) begin
        {receive_violation_flag_out, special_char_flag_out, parallel_data_out} <= buf_word[19:10];
        raw_ten_bit_out <= buf_word[9:0];
      end
    end
  end

  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);

  a_unassigned_code: assert property (
    char_end && dec_bad && !internal && !bist_run && !bypass_eff
    |=> pend_word_q == {2'h3, rxb_pkg::BAD_CODE})
    else $error("unassigned code not reported as E0 violation");
  a_bist_violation: assert property (
    char_end && bist_run && !internal && mismatch |=> pend_word_q[9])
    else $error("self-test mismatch did not raise violation");
  a_bist_expected: assert property (
    char_end && bist_run && !internal
    |=> pend_word_q[8:0] == {1'b0, $past(lfsr_q)})
    else $error("self-test output is not the expected pattern");
  a_bist_loop_pulse: assert property (
    char_end && bist_run |=> pend_pulse_q == (lfsr_q == rxb_pkg::BIST_SEED))
    else $error("self-test ready pulse not once per loop");
  a_bypass_override: assert property (
    char_end && mode_sel_in == rxb_pkg::MODE_BYP && bist_wait && !internal
    |=> pend_word_q == $past({dec_rvs, dec_sc, dec_data}))
    else $error("bypass not overridden during self-test");
  a_bypass_raw: assert property (
    char_end && bypass_eff && !bist_run |=> pend_word_q == pend_raw_q)
    else $error("bypass did not pass raw bits");
  a_test_clock: assert property (
    test_mode && !(serial_input_b_in && !sib_q) |=> $stable(shift_q))
    else $error("shifter moved without a test clock edge");
  a_internal_view: assert property (
    char_end && internal |=> pend_word_q[7:0] == $past(shift_q[7:0]))
    else $error("internal state not shown");
  a_comma_align: assert property (
    bit_stb && reframe_enable_in && comma_d |=> cnt_q == 4'h0 ##1 cnt_q != rxb_pkg::CNT_LAST)
    else $error("comma did not realign the boundary");
  a_sync_hold: assert property (
    char_end && st_q == rxb_pkg::ST_OFF && sync_wait_q && !comma_d |=> !pend_pulse_q)
    else $error("ready not inhibited while awaiting K28.5");
  a_ten_bits: assert property (
    !reframe_enable_in && bit_stb && cnt_q != rxb_pkg::CNT_LAST |-> !char_end)
    else $error("character ended before ten bits");

  c_bist_run: cover property (st_q == rxb_pkg::ST_WAIT ##1 st_q == rxb_pkg::ST_RUN);
  c_fill_drop: cover property (push && pend_pulse_q && fill);
  c_bad_code: cover property (char_end && dec_bad);
endmodule

// ---- rtl/rxb_pkg.sv ----
// Summary of operation
// - Self-test mismatch raises violation flag that byte
// - Ready pulses high once per self-test loop
// - Self-test outputs show expected pattern
// - Bypass with self-test decodes; bypass resumes after
// - Mode selects bypass, decoded or test
// - Test mode bit clock is serial_input_b
// - Test or self-test with reframe shows internals
// - Ten bits per character, all 256 bytes decoded
// - Bits A..H map to positions 0..7
// - Data chars flag low, special chars high
// - Comma pattern aligns the character boundary
// - Framer off without reframe; ready waits K28.5
// - Unassigned code gives violation, special, E0
package rxb_pkg;
  // ***************************************************
  // Modes, states and code constants
  // ***************************************************
  localparam logic [1:0] MODE_ENC = 2'h0;
  localparam logic [1:0] MODE_TEST = 2'h1;
  localparam logic [1:0] MODE_BYP = 2'h2;
  typedef enum logic [2:0] {
    ST_OFF = 3'h1,
    ST_WAIT = 3'h2,
    ST_RUN = 3'h4
  } rxb_bist_t;
  localparam logic [3:0] CNT_LAST = 4'h9;
  localparam logic [5:0] K28_6B = 6'h0F;
  localparam logic [3:0] ALT7_4B = 4'h7;
  localparam logic [9:0] K285_NEG = 10'h0FA;
  localparam logic [9:0] K285_POS = 10'h305;
  localparam logic [4:0] K28_X = 5'h1C;
  localparam logic [2:0] ALT7_Y = 3'h7;
  localparam logic [7:0] BAD_CODE = 8'hE0;
  localparam logic [7:0] BIST_INIT = 8'hFC;
  localparam logic [7:0] BIST_SEED = 8'h01;
  localparam int W_BUF = 22;
  localparam int D_BUF = 2;
  // Negative-disparity 6b and 4b codes, index is the unencoded value
  localparam logic [5:0] T6 [32] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0] T4 [8] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
endpackage

// ---- rtl/rxb_pair_buf.sv ----
`timescale 1ns/1ps
// Small FIFO between the decoder and the output latch; DEPTH must be a power of two
module rxb_pair_buf #(
  parameter int W = 22,
  parameter int DEPTH = 2
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic rdy_q;
  wire push = in_valid_in && rdy_q;
  wire pop = out_valid_out && out_ready_in;

  assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_valid_out = cnt_q != '0;
  assign out_data_out = mem_q[rp_q];
  assign in_ready_out = rdy_q;

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      wp_q <= wp_q + AW'(push);
      rp_q <= rp_q + AW'(pop);
      cnt_q <= cnt_d;
      rdy_q <= cnt_d != (AW+1)'(DEPTH);
    end
  end

  always_ff @(posedge clock_in) begin
    if (push) begin
      mem_q[wp_q] <= in_data_in;
    end
  end
endmodule

// ---- testbench/rxb_tx.sv ----
`timescale 1ns/1ps
// ****************************************
// Far-end sender: fill, bursts, self-test loop
// ****************************************
module rxb_tx (
  input wire logic clock_in,
  input wire logic rstn_in,
  output logic serial_out
);
  logic bq[$];
  logic [9:0] cq[$];
  logic bist = 1'b0;
  logic corrupt = 1'b0;
  logic [7:0] lfsr = 8'h01;
  initial serial_out = 1'b0;
  function automatic logic [9:0] enc(input logic [7:0] b);
    logic alt;
    alt = b[7:5] == 3'h7 && (b[4:0] == 5'h11 || b[4:0] == 5'h12 || b[4:0] == 5'h14);
    return {rxb_pkg::T6[b[4:0]], alt ? rxb_pkg::ALT7_4B : rxb_pkg::T4[b[7:5]]};
  endfunction
  // An idle sender keeps the line busy with fill, so the bit count never stalls
  always @(posedge clock_in) begin
    logic [9:0] c;
    if (!rstn_in) bq.delete();
    if (bq.size() == 0) begin
      c = rxb_pkg::K285_NEG;
      if (cq.size() > 0) c = cq.pop_front();
      else if (bist) begin
        c = enc(lfsr ^ {7'h00, corrupt});
        corrupt = 1'b0;
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      end
      for (int i = 9; i >= 0; i--) bq.push_back(c[i]);
    end
    serial_out <= bq.pop_front();
  end
endmodule

// ---- testbench/rxb_receiver_tb_top.sv ----
`timescale 1ns/1ps
module rxb_receiver_tb_top;
  localparam logic [9:0] KC = rxb_pkg::K285_NEG;
  localparam logic [9:0] KW = 10'h1BC;
  localparam logic [9:0] BAD = 10'h3E0;
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic serial_in;
  logic [1:0] mode_sel_in = rxb_pkg::MODE_ENC;
  logic self_test_enable_n_in = 1'b1;
  logic reframe_enable_in = 1'b0;
  logic host_ready_in = 1'b1;
  logic tclk = 1'b0;
  logic [7:0] parallel_data_out;
  logic special_char_flag_out;
  logic receive_violation_flag_out;
  logic [9:0] raw_ten_bit_out;
  logic byte_ready_n_out;
  logic rx_ready_out;
  logic [9:0] bc[$];
  logic [9:0] bw[$];
  logic [19:0] exq[$];
  logic [1:0] hr_mode = 2'h1;
  logic mon = 1'b0;
  logic byp = 1'b0;
  logic full_seen = 1'b0;
  logic [7:0] d;
  int seed = 43399;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  int hi;
  wire logic [9:0] word = {receive_violation_flag_out, special_char_flag_out, parallel_data_out};
  rxb_receiver i_rxb_receiver (
    .clock_in(clock_in), .rstn_in(rstn_in), .serial_in(serial_in), .serial_input_b_in(tclk),
    .mode_sel_in(mode_sel_in), .self_test_enable_n_in(self_test_enable_n_in),
    .reframe_enable_in(reframe_enable_in), .host_ready_in(host_ready_in),
    .parallel_data_out(parallel_data_out), .special_char_flag_out(special_char_flag_out),
    .receive_violation_flag_out(receive_violation_flag_out),
    .raw_ten_bit_out(raw_ten_bit_out), .byte_ready_n_out(byte_ready_n_out),
    .rx_ready_out(rx_ready_out)
  );
  rxb_tx i_rxb_tx (.clock_in(clock_in), .rstn_in(rstn_in), .serial_out(serial_in));
  initial forever #25 clock_in = ~clock_in;
  // ****************************************
  // Shared tasks and monitors
  // ****************************************
  task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] s);
    checked++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic finish_test();
    if (failures == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clock_in);
  endtask
  task automatic add(input logic [9:0] c, input logic [9:0] w);
    bc.push_back(c);
    bw.push_back(byp ? c : w);
  endtask
  task automatic rnd(input int k);
    repeat (k) begin
      d = 8'($random(seed));
      add(i_rxb_tx.enc(d), {2'h0, d});
    end
  endtask
  // Fill before the burst gets a word; fill followed by fill gets none
  task automatic go(input int keep);
    @(negedge clock_in);
    if (bc[0] != KC) exq.push_back({KC, byp ? KC : KW});
    foreach (bc[i]) begin
      if (!(bc[i] == KC && (i + 1 == bc.size() || bc[i + 1] == KC))) exq.push_back({bc[i], bw[i]});
      i_rxb_tx.cq.push_back(bc[i]);
    end
    while (exq.size() > keep) void'(exq.pop_back());
    tick(10 * bc.size() + 40);
    hr_mode <= 2'h1;
    tick(80);
    chk("drained", 20'h0, 20'(exq.size()));
    bc.delete();
    bw.delete();
  endtask
  always @(posedge clock_in) host_ready_in <= hr_mode[1] | (hr_mode[0] & (($random(seed) & 3) != 0));
  always @(posedge clock_in) begin
    cyc++;
    if (rx_ready_out === 1'b0) full_seen = 1'b1;
    if (mon && byte_ready_n_out === 1'b0)
      chk("word", exq.size() > 0 ? exq.pop_front() : 20'hXXXXX, {raw_ten_bit_out, word});
    if (cyc == 12000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    tick(2);
    chk("reset", 20'h400, 20'({rx_ready_out, byte_ready_n_out, word}));
    rstn_in <= 1'b1;
    tick(2);
    chk("rx_ready", 20'h1, 20'(rx_ready_out));
    mon <= 1'b1;
    repeat (2) begin
      rnd(24);
      add(KC, KW);
      add(KC, KW);
      add(10'h000, BAD);
    end
    go(999);
    // Long host stall: fill words occupy the buffer first, so the whole burst is lost
    hr_mode <= 2'h0;
    full_seen = 1'b0;
    tick(40);
    rnd(6);
    go(0);
    chk("full", 20'h1, 20'(full_seen));
    reframe_enable_in <= 1'b1;
    tick(30);
    @(negedge clock_in);
    // The K28.5 before the slip and the skewed character both count as usable
    exq.push_back({KC, KW});
    exq.push_back({10'h01F, BAD});
    repeat (3) i_rxb_tx.bq.push_back(1'b0);
    tick(80);
    reframe_enable_in <= 1'b0;
    rnd(20);
    go(999);
    mode_sel_in <= rxb_pkg::MODE_BYP;
    hr_mode <= 2'h2;
    mon <= 1'b0;
    tick(40);
    @(negedge clock_in);
    i_rxb_tx.cq.push_back({rxb_pkg::K28_6B, 4'h8});
    i_rxb_tx.lfsr = rxb_pkg::BIST_SEED;
    i_rxb_tx.bist = 1'b1;
    @(posedge clock_in);
    self_test_enable_n_in <= 1'b0;
    n = 0;
    while (byte_ready_n_out !== 1'b0 && n < 200) begin
      tick(1);
      n++;
    end
    // Ready idles low once the run starts; the init word lands a character later
    n = 0;
    while (word !== {2'h1, rxb_pkg::BIST_INIT} && n < 40) begin
      tick(1);
      n++;
    end
    chk("init", {12'h1, rxb_pkg::BIST_INIT}, 20'(word));
    d = rxb_pkg::BIST_SEED;
    repeat (254) d = {d[6:0], d[7] ^ d[5] ^ d[4] ^ d[3]};
    hi = 0;
    n = 0;
    repeat (5200) begin
      tick(1);
      if (byte_ready_n_out === 1'b1) begin
        hi++;
        chk("loop_end", {12'h0, d}, 20'(word));
      end
      n += (receive_violation_flag_out !== 1'b0);
    end
    chk("loops", 20'h2, 20'(hi));
    chk("clean", 20'h0, 20'(n));
    @(negedge clock_in);
    i_rxb_tx.corrupt = 1'b1;
    n = 0;
    repeat (200) begin
      tick(1);
      n += (receive_violation_flag_out === 1'b1);
    end
    chk("mismatch", 20'hA, 20'(n));
    self_test_enable_n_in <= 1'b1;
    @(negedge clock_in);
    i_rxb_tx.bist = 1'b0;
    tick(80);
    exq.delete();
    byp = 1'b1;
    mon <= 1'b1;
    hr_mode <= 2'h1;
    rnd(16);
    add(10'h000, BAD);
    go(999);
    // Test mode: characters advance only on rises of the external bit clock
    mon <= 1'b0;
    mode_sel_in <= rxb_pkg::MODE_TEST;
    tick(60);
    n = 0;
    repeat (100) begin
      tick(1);
      n += (byte_ready_n_out === 1'b0);
    end
    chk("tclk_idle", 20'h0, 20'(n));
    n = 0;
    hi = 0;
    repeat (400) begin
      tick(1);
      tclk <= ~tclk;
      if (byte_ready_n_out === 1'b0) begin
        n++;
        // The first word was captured before test mode began
        if (n > 1) hi += (word[9:8] !== 2'h0);
      end
    end
    chk("tclk_words", 20'h1, 20'(n > 1));
    chk("internal", 20'h0, 20'(hi));
    finish_test();
  end
endmodule
